// >>> core/dram_page_ctrl.sv
`timescale 1ns/1ps
module dram_page_ctrl
    import dram_page_pkg::*;
(
    input wire logic clk, // System clock, 40 MHz.
    input wire logic nrst, // Asynchronous reset, active low.
    input wire logic page_burst_enable, // Burst on row hit.
    input wire logic strobe_style_select, // 0 dual column strobe, 1 dual write strobe.
    input wire logic column_strobe_duty_select, // 0 high 50%, 1 high 35%.
    input wire logic area1_read_pitch, // Full access read pitch, 1 long.
    input wire logic area1_write_pitch, // Full access write pitch, 1 long.
    input wire logic area1_dram_read_pitch, // Burst read pitch, 1 long.
    input wire logic area1_dram_write_pitch, // Burst write pitch, 1 long.
    input wire logic row_strobe_hold_select, // 1 hold row strobe low between accesses when page burst is enabled.
    input wire logic req_valid, // DRAM access request pending.
    input wire logic req_write, // Request is a write.
    input wire logic req_wide, // Request targets 16-bit space.
    input wire logic req_upper, // Upper byte lane requested.
    input wire logic req_lower, // Lower byte lane requested.
    input wire logic [ROW_W-1:0] req_row, // Row part of the request address.
    input wire logic refresh_req, // DRAM refresh wants the row strobe high.
    input wire logic wait_n, // Wait pin, active low, asynchronous.
    output logic req_taken, // One-cycle pulse: request captured.
    output logic refresh_ready, // Row strobe is high and the machine idle while refresh is requested.
    output logic column_phase, // Address mux shows the column address.
    output logic row_strobe_n, // Row strobe, active low.
    output logic column_strobe_upper_n, // Upper column strobe, active low.
    output logic column_strobe_lower_n, // Lower column strobe, active low.
    output logic write_strobe_upper_n, // Upper write strobe, active low.
    output logic write_strobe_lower_n // Lower write strobe, active low.
);
    logic [TICK_W-1:0] tick;
    logic tick_last;
    logic cas_hi_en;
    logic cas_lo_en;
    logic wr_hi_en;
    logic wr_lo_en;
    logic wait_meta_q;
    logic wait_s_q;
    state_t state_q, state_d;
    logic [ROW_W-1:0] row_q, row_d;
    logic row_valid_q, row_valid_d;
    logic write_q, write_d;
    logic wide_q, wide_d;
    logic upper_q, upper_d;
    logic lower_q, lower_d;
    logic long_q, long_d;
    logic taken_q, taken_d;
    logic ras_n_q, ras_n_d;
    logic col_phase_q, col_phase_d;
    logic cas_hi_n_q, cas_hi_n_d;
    logic cas_lo_n_q, cas_lo_n_d;
    logic wr_hi_n_q, wr_hi_n_d;
    logic wr_lo_n_q, wr_lo_n_d;
    logic ready_q, ready_d;
    logic hit;
    logic burst_long;
    logic full_long;
    logic col_end;
    logic cas_act;
    logic [TICK_W-1:0] high_ticks;

    state_tick u_tick (
        .clk(clk),
        .nrst(nrst),
        .tick(tick),
        .tick_last(tick_last)
    );

    lane_strobe_map u_lanes (
        .wide(wide_q),
        .style(strobe_style_select),
        .upper(upper_q),
        .lower(lower_q),
        .write(write_q),
        .cas_hi_en(cas_hi_en),
        .cas_lo_en(cas_lo_en),
        .wr_hi_en(wr_hi_en),
        .wr_lo_en(wr_lo_en)
    );

    // The wait pin is asynchronous; only the second stage is read.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wait_meta_q <= 1'b1;
            wait_s_q <= 1'b1;
        end else begin
            wait_meta_q <= wait_n;
            wait_s_q <= wait_meta_q;
        end
    end

    // Row hit against the open page.
    assign hit = page_burst_enable && row_valid_q && (req_row == row_q);
    // Separate read and write pitch bits.
    assign burst_long = req_write ? area1_dram_write_pitch : area1_dram_read_pitch;
    assign full_long = req_write ? area1_write_pitch : area1_read_pitch;
    // Second column state ends only on a high wait sample.
    assign col_end = (state_q == st_col && !long_q) || (state_q == st_col2 && wait_s_q);

    always_comb begin
        state_d = state_q;
        row_d = row_q;
        row_valid_d = row_valid_q;
        write_d = write_q;
        wide_d = wide_q;
        upper_d = upper_q;
        lower_d = lower_q;
        long_d = long_q;
        taken_d = 1'b0;
        if (tick_last) begin
            unique case (state_q)
                st_idle, st_pre: begin
                    row_valid_d = 1'b0;
                    if (req_valid && !refresh_req) begin
                        // Full access starts with the row state.
                        state_d = st_row;
                        row_d = req_row;
                        row_valid_d = 1'b1;
                        long_d = full_long;
                        taken_d = 1'b1;
                    end else begin
                        state_d = st_idle;
                    end
                end
                st_row, st_silent: begin
                    state_d = st_col;
                end
                st_col, st_col2, st_hold: begin
                    if (state_q == st_col && long_q) begin
                        // Long pitch column takes two states.
                        state_d = st_col2;
                    end else if (state_q == st_col2 && !col_end) begin
                        // Wait low repeats the second column state.
                        state_d = st_col2;
                    end else if (refresh_req) begin
                        // Refresh forces the row strobe high.
                        state_d = st_pre;
                    end else if (req_valid && hit) begin
                        long_d = burst_long;
                        taken_d = 1'b1;
                        // Short pitch write gets one silent state.
                        state_d = (req_write && !burst_long) ? st_silent : st_col;
                    end else if (req_valid) begin
                        // Row miss closes the page first.
                        state_d = st_pre;
                    end else if (row_strobe_hold_select && page_burst_enable) begin
                        // Page stays open while other space runs.
                        state_d = st_hold;
                    end else begin
                        // Pause in release mode closes the page.
                        state_d = st_pre;
                    end
                    if (taken_d) begin
                        write_d = req_write;
                        wide_d = req_wide;
                        upper_d = req_upper;
                        lower_d = req_lower;
                    end
                end
                default: begin
                    state_d = st_idle;
                end
            endcase
            if (taken_d && state_d == st_row) begin
                write_d = req_write;
                wide_d = req_wide;
                upper_d = req_upper;
                lower_d = req_lower;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= st_idle;
            row_q <= ROW_RESET;
            row_valid_q <= 1'b0;
            write_q <= 1'b0;
            wide_q <= 1'b0;
            upper_q <= 1'b0;
            lower_q <= 1'b0;
            long_q <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            state_q <= state_d;
            row_q <= row_d;
            row_valid_q <= row_valid_d;
            write_q <= write_d;
            wide_q <= wide_d;
            upper_q <= upper_d;
            lower_q <= lower_d;
            long_q <= long_d;
            taken_q <= taken_d;
        end
    end

    // Column strobe stays high for the selected share of the state.
    assign high_ticks = column_strobe_duty_select ? HIGH_TICKS_SHORT : HIGH_TICKS_NORMAL;
    // Short pitch column strobe falls inside its single state.
    assign cas_act = (state_q == st_col && !long_q && tick >= high_ticks) || state_q == st_col2;

    always_comb begin
        ras_n_d = (state_q == st_idle) || (state_q == st_pre);
        col_phase_d = (state_q == st_col) || (state_q == st_col2) || (state_q == st_silent);
        cas_hi_n_d = !(cas_act && cas_hi_en);
        cas_lo_n_d = !(cas_act && cas_lo_en);
        wr_hi_n_d = !((state_q == st_col || state_q == st_col2) && wr_hi_en);
        wr_lo_n_d = !((state_q == st_col || state_q == st_col2) && wr_lo_en);
        ready_d = (state_q == st_idle) && refresh_req;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ras_n_q <= 1'b1;
            col_phase_q <= 1'b0;
            cas_hi_n_q <= 1'b1;
            cas_lo_n_q <= 1'b1;
            wr_hi_n_q <= 1'b1;
            wr_lo_n_q <= 1'b1;
            ready_q <= 1'b0;
        end else begin
            ras_n_q <= ras_n_d;
            col_phase_q <= col_phase_d;
            cas_hi_n_q <= cas_hi_n_d;
            cas_lo_n_q <= cas_lo_n_d;
            wr_hi_n_q <= wr_hi_n_d;
            wr_lo_n_q <= wr_lo_n_d;
            ready_q <= ready_d;
        end
    end

    assign req_taken = taken_q;
    assign refresh_ready = ready_q;
    assign column_phase = col_phase_q;
    assign row_strobe_n = ras_n_q;
    assign column_strobe_upper_n = cas_hi_n_q;
    assign column_strobe_lower_n = cas_lo_n_q;
    assign write_strobe_upper_n = wr_hi_n_q;
    assign write_strobe_lower_n = wr_lo_n_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_dual_cas_no_wr_hi;
        $past(wide_q && !strobe_style_select) |-> write_strobe_upper_n;
    endproperty
    a_dual_cas_no_wr_hi: assert property (p_dual_cas_no_wr_hi)
        else $error("Upper write strobe active in dual column strobe mode.");

    property p_dual_we_no_cas_hi;
        $past(wide_q && strobe_style_select) |-> column_strobe_upper_n;
    endproperty
    a_dual_we_no_cas_hi: assert property (p_dual_we_no_cas_hi)
        else $error("Upper column strobe active in dual write strobe mode.");

    property p_byte_space_lower;
        !$past(wide_q) |-> column_strobe_upper_n && write_strobe_upper_n;
    endproperty
    a_byte_space_lower: assert property (p_byte_space_lower)
        else $error("Upper strobe active in byte space.");

    property p_burst_hit;
        (tick_last && state_q == st_col && !long_q && req_valid && hit && !refresh_req)
            |=> (state_q == st_col || state_q == st_silent) && req_taken;
    endproperty
    a_burst_hit: assert property (p_burst_hit)
        else $error("Row hit did not continue the burst.");

    property p_miss_precharge;
        (state_q == st_row) |-> $past(state_q) == st_row || $past(state_q) == st_pre
            || $past(state_q) == st_idle;
    endproperty
    a_miss_precharge: assert property (p_miss_precharge)
        else $error("Row state entered without a closed page.");

    property p_short_no_col2;
        (state_q == st_col2) |-> long_q;
    endproperty
    a_short_no_col2: assert property (p_short_no_col2)
        else $error("Short pitch entered a second column state.");

    property p_silent_one_state;
        (state_q != st_silent ##1 state_q == st_silent) |-> ##19 state_q == st_silent
            ##1 state_q == st_col;
    endproperty
    a_silent_one_state: assert property (p_silent_one_state)
        else $error("Silent cycle is not exactly one state.");

    property p_duty_normal;
        (state_q == st_col && !long_q && tick == 0 && !column_strobe_duty_select && lower_q)
            |-> ##10 column_strobe_lower_n ##1 !column_strobe_lower_n;
    endproperty
    a_duty_normal: assert property (p_duty_normal)
        else $error("Column strobe high time is not half the state.");

    property p_wait_repeat;
        (state_q == st_col2 && tick_last && !wait_s_q) |=> state_q == st_col2;
    endproperty
    a_wait_repeat: assert property (p_wait_repeat)
        else $error("Wait low did not repeat the second column state.");

    property p_hold_low;
        (state_q == st_hold && $past(state_q) == st_hold) |-> !row_strobe_n;
    endproperty
    a_hold_low: assert property (p_hold_low)
        else $error("Row strobe not held low in hold mode.");

    property p_refresh_release;
        (state_q == st_hold && refresh_req) |-> ##[1:20] state_q == st_pre;
    endproperty
    a_refresh_release: assert property (p_refresh_release)
        else $error("Refresh did not release the held row strobe.");

    property p_release_mode;
        (state_q == st_hold) |-> row_strobe_hold_select && page_burst_enable;
    endproperty
    a_release_mode: assert property (p_release_mode)
        else $error("Page held open in release mode.");
endmodule : dram_page_ctrl

// >>> core/dram_page_pkg.sv
package dram_page_pkg;
    // Width of the row part of a DRAM address compared for page hits.
    localparam int unsigned ROW_W = 14;
    // One bus state spans this many clocks, so strobe duty can be set within a state.
    localparam int unsigned STATE_TICKS = 20;
    localparam int unsigned TICK_W = 5;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(STATE_TICKS - 1);
    // Column strobe high time in short pitch, in percent of the column state.
    localparam int unsigned DUTY_NORMAL_PCT = 50;
    localparam int unsigned DUTY_SHORT_PCT = 35;
    localparam logic [TICK_W-1:0] HIGH_TICKS_NORMAL = TICK_W'(STATE_TICKS * DUTY_NORMAL_PCT / 100);
    localparam logic [TICK_W-1:0] HIGH_TICKS_SHORT = TICK_W'(STATE_TICKS * DUTY_SHORT_PCT / 100);
    localparam logic [ROW_W-1:0] ROW_RESET = '0;

    typedef enum logic [6:0] {
        st_idle = 7'h01,
        st_row = 7'h02,
        st_col = 7'h04,
        st_col2 = 7'h08,
        st_silent = 7'h10,
        st_hold = 7'h20,
        st_pre = 7'h40
    } state_t;
endpackage : dram_page_pkg

// >>> core/lane_strobe_map.sv
`timescale 1ns/1ps
module lane_strobe_map (
    input wire logic wide, // Access is to 16-bit DRAM space.
    input wire logic style, // Strobe style select: 0 dual column, 1 dual write.
    input wire logic upper, // Upper byte lane is accessed.
    input wire logic lower, // Lower byte lane is accessed.
    input wire logic write, // Access is a write.
    output logic cas_hi_en, // Upper column strobe takes part.
    output logic cas_lo_en, // Lower column strobe takes part.
    output logic wr_hi_en, // Upper write strobe takes part.
    output logic wr_lo_en // Lower write strobe takes part.
);
    always_comb begin
        cas_hi_en = 1'b0;
        cas_lo_en = 1'b1;
        wr_hi_en = 1'b0;
        wr_lo_en = write;
        if (wide && !style) begin
            cas_hi_en = upper;
            cas_lo_en = lower;
        end else if (wide) begin
            wr_hi_en = write && upper;
            wr_lo_en = write && lower;
        end
        // Byte space uses lower strobes only, as set by the defaults above.
    end
endmodule : lane_strobe_map

// >>> core/state_tick.sv
`timescale 1ns/1ps
module state_tick
    import dram_page_pkg::*;
(
    input wire logic clk, // System clock.
    input wire logic nrst, // Asynchronous reset, active low.
    output logic [TICK_W-1:0] tick, // Clock position inside the bus state.
    output logic tick_last // High on the last clock of a bus state.
);
    logic [TICK_W-1:0] tick_q;
    logic [TICK_W-1:0] tick_d;

    always_comb begin
        tick_d = (tick_q == TICK_LAST) ? '0 : tick_q + TICK_W'(1);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tick_q <= '0;
        end else begin
            tick_q <= tick_d;
        end
    end

    assign tick = tick_q;
    assign tick_last = (tick_q == TICK_LAST);
endmodule : state_tick

// >>> verification/dram_chip_model.sv
`timescale 1ns/1ps
module dram_chip_model (
    input wire logic clk, // System clock.
    input wire logic nrst, // Reset, active low.
    input wire logic cas_n, // Lower column strobe seen by the chip.
    input wire logic [7:0] wait_len, // Clocks of wait after each strobe fall.
    output logic wait_n // Wait pin back to the controller.
);
    logic [7:0] cnt_q;
    logic cas_prev_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= 8'h00;
            cas_prev_q <= 1'b1;
        end else begin
            cas_prev_q <= cas_n;
            if (cas_prev_q && !cas_n) begin
                cnt_q <= wait_len;
            end else if (cnt_q != 8'h00) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
    // The wait line has a pull-up, so once the chip lets go it reads high.
    assign wait_n = (cnt_q == 8'h00);
endmodule : dram_chip_model

// >>> verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dram_page_pkg::*;
    logic clk, nrst, be, style, duty, rp, wp, drp, dwp, hold, req_valid, req_write;
    logic req_wide, req_upper, req_lower, refresh_req, wait_n, req_taken, refresh_ready;
    logic column_phase, ras_n, cu_n, cl_n, wu_n, wl_n, clr, ras_p, cl_p;
    logic [ROW_W-1:0] req_row;
    logic [7:0] wait_len;
    logic [15:0] cyc = 16'h0;
    logic [15:0] cl_last = 16'h0;
    logic [15:0] lo_cu, lo_cl, lo_wu, lo_wl, ras_fall, cl_gap, cp_cnt;
    int bad_count, compares;
    // Rows: wide, style, upper, lower, write, then cas_hi cas_lo wr_hi wr_lo.
    logic [8:0] lane_tab [7] = '{9'h159, 9'h124, 9'h16c, 9'h1d6, 9'h1e4, 9'h035, 9'h0f5};

    dram_page_ctrl u_dram_page_ctrl (.clk(clk), .nrst(nrst), .page_burst_enable(be),
        .strobe_style_select(style), .column_strobe_duty_select(duty),
        .area1_read_pitch(rp), .area1_write_pitch(wp), .area1_dram_read_pitch(drp),
        .area1_dram_write_pitch(dwp), .row_strobe_hold_select(hold), .req_valid(req_valid),
        .req_write(req_write), .req_wide(req_wide), .req_upper(req_upper),
        .req_lower(req_lower), .req_row(req_row), .refresh_req(refresh_req),
        .wait_n(wait_n), .req_taken(req_taken), .refresh_ready(refresh_ready),
        .column_phase(column_phase), .row_strobe_n(ras_n), .column_strobe_upper_n(cu_n),
        .column_strobe_lower_n(cl_n), .write_strobe_upper_n(wu_n),
        .write_strobe_lower_n(wl_n));
    dram_chip_model u_dram_chip_model (.clk(clk), .nrst(nrst), .cas_n(cl_n),
        .wait_len(wait_len), .wait_n(wait_n));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Strobe activity is counted here so tests read totals; the hold and reset tests also sample strobes.
    always @(posedge clk) begin
        cyc <= cyc + 16'h1;
        ras_p <= ras_n;
        cl_p <= cl_n;
        if (clr) begin
            {lo_cu, lo_cl, lo_wu, lo_wl, ras_fall, cl_gap, cp_cnt} <= '0;
        end else begin
            if (column_phase === 1'b1) cp_cnt <= cp_cnt + 16'h1;
            if (cu_n === 1'b0) lo_cu <= lo_cu + 16'h1;
            if (cl_n === 1'b0) lo_cl <= lo_cl + 16'h1;
            if (wu_n === 1'b0) lo_wu <= lo_wu + 16'h1;
            if (wl_n === 1'b0) lo_wl <= lo_wl + 16'h1;
            if (ras_p === 1'b1 && ras_n === 1'b0) ras_fall <= ras_fall + 16'h1;
            if (cl_p === 1'b1 && cl_n === 1'b0) begin
                cl_gap <= cyc - cl_last;
                cl_last <= cyc;
            end
        end
    end

    task automatic final_report();
        $display("bad_count=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
            bad_count++;
        end
    endtask : chk

    task automatic access(input logic w, input logic [ROW_W-1:0] row);
        int n;
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_row <= row;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (req_taken !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            final_report();
        end
    endtask : access

    task automatic idle(input int n);
        @(posedge clk);
        req_valid <= 1'b0;
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic clear();
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
    endtask : clear

    task automatic one(input logic w, input logic [15:0] exp);
        clear();
        access(w, 14'h0005);
        idle(120);
        chk(lo_cl, exp);
    endtask : one

    task automatic pair(input logic w1, input logic w2, input logic [15:0] gap,
                        input logic [15:0] falls);
        clear();
        access(w1, 14'h0123);
        access(w2, 14'h0123);
        idle(120);
        if (gap != 16'h0) chk(cl_gap, gap);
        chk(ras_fall, falls);
    endtask : pair

    initial begin
        int n;
        {nrst, be, style, duty, rp, wp, drp, dwp, hold, req_valid, req_write} = '0;
        {req_wide, req_upper, req_lower, refresh_req, clr} = '0;
        req_row = '0;
        wait_len = 8'h00;
        bad_count = 0;
        compares = 0;
        repeat (19) @(posedge clk);
        @(negedge clk);
        chk({10'h0, column_phase, req_taken, refresh_ready, ras_n, cu_n, cl_n},
            16'h0007);
        chk({14'h0, wu_n, wl_n}, 16'h0003);
        @(posedge clk);
        nrst <= 1'b1;
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            clear();
            style <= lane_tab[i][7];
            req_wide <= lane_tab[i][8];
            req_upper <= lane_tab[i][6];
            req_lower <= lane_tab[i][5];
            access(lane_tab[i][4], 14'(i));
            idle(80);
            chk({12'h0, lo_cu != 0, lo_cl != 0, lo_wu != 0, lo_wl != 0},
                {12'h0, lane_tab[i][3:0]});
        end
        $display("test lanes done");
        {req_wide, req_upper, req_lower, style} <= 4'h2;
        one(1'b0, 16'(STATE_TICKS) - 16'(HIGH_TICKS_NORMAL));
        chk(cp_cnt, 16'(STATE_TICKS));
        duty <= 1'b1;
        one(1'b0, 16'(STATE_TICKS) - 16'(HIGH_TICKS_SHORT));
        duty <= 1'b0;
        wait_len <= 8'd30;
        one(1'b0, 16'(STATE_TICKS) - 16'(HIGH_TICKS_NORMAL));
        rp <= 1'b1;
        one(1'b1, 16'(STATE_TICKS) - 16'(HIGH_TICKS_NORMAL));
        one(1'b0, 16'(2 * STATE_TICKS));
        wait_len <= 8'h00;
        one(1'b0, 16'(STATE_TICKS));
        rp <= 1'b0;
        $display("test pitch and wait done");
        pair(1'b0, 1'b0, 16'h0, 16'h2);
        be <= 1'b1;
        pair(1'b0, 1'b0, 16'(STATE_TICKS), 16'h1);
        pair(1'b1, 1'b1, 16'(2 * STATE_TICKS), 16'h1);
        pair(1'b0, 1'b1, 16'(2 * STATE_TICKS), 16'h1);
        drp <= 1'b1;
        // Short column falls mid-state, the long burst's only in its second state.
        pair(1'b0, 1'b0, 16'(2 * STATE_TICKS) - 16'(HIGH_TICKS_NORMAL), 16'h1);
        drp <= 1'b0;
        $display("test burst done");
        access(1'b0, 14'h0040);
        idle(80);
        chk({15'h0, ras_n}, 16'h1);
        hold <= 1'b1;
        clear();
        access(1'b0, 14'h0040);
        idle(80);
        chk({15'h0, ras_n}, 16'h0);
        access(1'b0, 14'h0040);
        idle(80);
        chk(ras_fall, 16'h1);
        access(1'b0, 14'h0041);
        idle(120);
        chk(ras_fall, 16'h2);
        refresh_req <= 1'b1;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (refresh_ready !== 1'b1 && n < 200);
        if (n >= 200) begin
            bad_count++;
            final_report();
        end
        chk({15'h0, ras_n}, 16'h1);
        @(posedge clk);
        refresh_req <= 1'b0;
        $display("test hold done");
        // A reset one clock into a row state must leave every strobe high three clocks later.
        access(1'b0, 14'h0040);
        @(posedge clk);
        nrst <= 1'b0;
        req_valid <= 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        chk({10'h0, column_phase, req_taken, refresh_ready, ras_n, cu_n, cl_n},
            16'h0007);
        chk({14'h0, wu_n, wl_n}, 16'h0003);
        @(posedge clk);
        nrst <= 1'b1;
        @(negedge clk);
        chk({10'h0, column_phase, req_taken, refresh_ready, ras_n, cu_n, cl_n},
            16'h0007);
        $display("test mid reset done");
        final_report();
    end
endmodule : tb_top
